//--- bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module bit_timer #(
    parameter int unsigned W = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clr_i,
    input wire logic load_i,
    input wire logic [W-1:0] len_i,
    // Interval end
    output logic tick_o
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // Load restarts the interval; zero means stopped
    assign nxt_cnt = clr_i ? '0 :
                     load_i ? len_i :
                     (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    assign tick_o = (cnt_ff == W'(1));

    // Counter state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

//--- far_end.sv
`timescale 1ns/1ps
`default_nettype none
module far_end #(
    parameter int K = 8
) (
    // Clock
    input wire logic clk_i,
    // Line into the block
    output logic line_o
);
    initial line_o = 1'b1;
    // Whole frame LSB first, back to idle high so no false edge follows
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line_o <= f[i];
            repeat (2 * K) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    // Short low pulse that the start check has to reject
    task automatic glitch(input int n);
        line_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        line_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

//--- tb_uart_txrx.sv
`timescale 1ns/1ps
`default_nettype none
module tb_uart_txrx;
    logic clk_i = 0, rst_i = 1, awvalid_i = 0, wvalid_i = 0, bready_i = 0;
    logic arvalid_i = 0, rready_i = 0, awready_o, wready_o, bvalid_o;
    logic [4:0] awaddr_i = '0, araddr_i = '0;
    logic [31:0] wdata_i = '0, rdata_o, d;
    logic [3:0] wstrb_i = 4'hf;
    logic out_pin_dir_bit_i = 0, out_pin_latch_i = 1, in_pin_dir_bit_i = 1;
    logic [1:0] bresp_o, rresp_o, r;
    logic arready_o, rvalid_o, serial_out_pin_o, serial_out_pin_oe_o;
    logic tx_done_irq_o, rx_done_irq_o, rx_err_irq_o;
    wire serial_in_pin_i;
    int n_fail = 0, total_checks = 0, cyc = 0, ntx = 0, nrx = 0, ner = 0;
    // Rows: mode, data, expected frame LSB first, frame length
    logic [7:0] md[6] = '{8'hfd, 8'hf3, 8'he5, 8'hed, 8'hf5, 8'hf9};
    logic [7:0] dt[6] = '{8'h55, 8'h36, 8'h87, 8'h01, 8'h00, 8'hff};
    logic [11:0] fr[6] = '{12'h4aa, 12'h76c, 12'h30e, 12'h402, 12'h600,
        12'h3fe};
    int nb[6] = '{11, 11, 10, 11, 11, 10};
    always #12.5 clk_i = ~clk_i;
    uart_txrx dut (.clk_i, .rst_i, .awvalid_i, .awready_o, .awaddr_i,
        .wvalid_i, .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .bready_i,
        .bresp_o, .arvalid_i, .arready_o, .araddr_i, .rvalid_o, .rready_i,
        .rdata_o, .rresp_o, .out_pin_dir_bit_i, .out_pin_latch_i,
        .in_pin_dir_bit_i, .serial_in_pin_i, .serial_out_pin_o,
        .serial_out_pin_oe_o, .tx_done_irq_o, .rx_done_irq_o, .rx_err_irq_o);
    far_end far (.clk_i, .line_o(serial_in_pin_i));
    // Pulses are one cycle wide, so count them rather than poll
    always @(posedge clk_i) begin
        ntx <= ntx + (tx_done_irq_o === 1'b1);
        nrx <= nrx + (rx_done_irq_o === 1'b1);
        ner <= ner + (rx_err_irq_o === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        logic pa = 1, pw = 1;
        awaddr_i <= a;
        wdata_i <= v;
        awvalid_i <= 1;
        wvalid_i <= 1;
        bready_i <= 1;
        while (pa || pw) begin
            @(posedge clk_i);
            if (pa && awready_o === 1'b1) begin
                pa = 0;
                awvalid_i <= 0;
            end
            if (pw && wready_o === 1'b1) begin
                pw = 0;
                wvalid_i <= 0;
            end
        end
        // Response ready stays high so back-to-back calls never toggle it
        while (bvalid_o !== 1'b1) @(posedge clk_i);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v,
        output logic [1:0] rr);
        araddr_i <= a;
        arvalid_i <= 1;
        rready_i <= 1;
        do @(posedge clk_i); while (arready_o !== 1'b1);
        arvalid_i <= 0;
        do @(posedge clk_i); while (rvalid_o !== 1'b1);
        v = rdata_o;
        rr = rresp_o;
    endtask
    // Sample the outgoing line near each bit centre
    task automatic txw(input int i);
        while (serial_out_pin_o !== 1'b0) @(posedge clk_i);
        repeat (7) @(posedge clk_i);
        for (int b = 0; b < nb[i]; b++) begin
            chk("tx bit", fr[i][b], serial_out_pin_o);
            repeat (16) @(posedge clk_i);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        rd(5'h00, d, r);
        chk("mode reset", 32'h01, d);
        chk("read resp", 32'h0, r);
        rd(5'h08, d, r);
        chk("divider reset", 32'h1f, d);
        rd(5'h14, d, r);
        chk("unmapped resp", 32'h2, r);
        wr(5'h08, 32'h08);
        chk("write resp", 32'h0, bresp_o);
        // Lane 0 strobe low must leave the divider alone
        wstrb_i <= 4'he;
        wr(5'h08, 32'h10);
        wstrb_i <= 4'hf;
        rd(5'h08, d, r);
        chk("masked write", 32'h08, d);
        wr(5'h14, 32'h00);
        chk("bad write resp", 32'h2, bresp_o);
        for (int i = 0; i < 6; i++) begin
            // Format first, then power, then the enables
            wr(5'h00, md[i] & 8'h1f);
            wr(5'h00, md[i] & 8'h9f);
            wr(5'h00, md[i]);
            repeat (2) @(posedge clk_i);
            chk("oe", 1, serial_out_pin_oe_o);
            fork
                wr(5'h0c, dt[i]);
                txw(i);
                far.send(fr[i], nb[i]);
            join
            repeat (40) @(posedge clk_i);
            chk("tx done", i + 1, ntx);
            chk("rx done", i + 1, nrx);
            rd(5'h04, d, r);
            chk("status", 0, d);
            rd(5'h10, d, r);
            chk("rx data", md[i][2] ? dt[i] : {1'b0, dt[i][6:0]}, d);
        end
        // Bad parity, then bad stop, then a frame onto a full buffer
        wr(5'h00, 32'hfd);
        far.send(12'h6aa, 11);
        repeat (40) @(posedge clk_i);
        chk("err irq", 1, ner);
        rd(5'h04, d, r);
        chk("parity flag", 32'h4, d);
        rd(5'h04, d, r);
        chk("flags cleared", 0, d);
        rd(5'h10, d, r);
        chk("data kept on parity", 32'h55, d);
        far.send(12'h0aa, 11);
        repeat (40) @(posedge clk_i);
        rd(5'h04, d, r);
        chk("framing flag", 32'h2, d);
        far.send(12'h602, 11);
        repeat (40) @(posedge clk_i);
        chk("err irqs", 3, ner);
        rd(5'h04, d, r);
        chk("overrun flag", 32'h1, d);
        rd(5'h10, d, r);
        chk("old data kept", 32'h55, d);
        // A low pulse shorter than half a bit is no start bit
        far.glitch(4);
        repeat (40) @(posedge clk_i);
        chk("glitch done", 6, nrx);
        chk("glitch err", 3, ner);
        // Receive pin set as output: the receiver sees only high
        in_pin_dir_bit_i <= 0;
        far.send(12'h4aa, 11);
        repeat (40) @(posedge clk_i);
        chk("gated rx", 6, nrx);
        chk("gated err", 3, ner);
        in_pin_dir_bit_i <= 1;
        out_pin_latch_i <= 0;
        repeat (2) @(posedge clk_i);
        chk("oe off", 0, serial_out_pin_oe_o);
        wr(5'h00, 32'h01);
        rd(5'h10, d, r);
        chk("buffer off", 0, d);
        end_of_test();
    end
endmodule
`default_nettype wire

//--- uart_pkg.sv
package uart_pkg;
    // Register byte addresses on the 32-bit slave
    localparam int unsigned ADDR_W = 5;
    localparam logic [ADDR_W-1:0] UART_MODE_OFF = 5'h00;
    localparam logic [ADDR_W-1:0] RX_ERROR_STATUS_OFF = 5'h04;
    localparam logic [ADDR_W-1:0] BAUD_DIVIDER_OFF = 5'h08;
    localparam logic [ADDR_W-1:0] TX_SHIFT_OFF = 5'h0c;
    localparam logic [ADDR_W-1:0] RX_BUFFER_OFF = 5'h10;

    // Reset values
    localparam logic [7:0] UART_MODE_RST = 8'h01;
    localparam logic [4:0] BAUD_DIVIDER_RST = 5'h1f;
    localparam logic [7:0] RX_BUFFER_RST = 8'h00;

    // Smallest legal divider; lower settings are run at this value
    localparam logic [4:0] DIVIDER_MIN = 5'h08;

    // Last character bit index for 7 and 8 bit characters
    localparam logic [2:0] LAST_BIT_7 = 3'h6;
    localparam logic [2:0] LAST_BIT_8 = 3'h7;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ZERO = 2'h1,
        PAR_ODD = 2'h2,
        PAR_EVEN = 2'h3
    } parity_e;

    // Mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic uart_power_on;
        logic tx_enable_bit;
        logic rx_enable_bit;
        parity_e parity_sel;
        logic char_length_sel;
        logic stop_length_sel;
        logic fixed_one;
    } uart_mode_s;

    // Error status layout, bit 2 down to bit 0
    typedef struct packed {
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_flag;
    } rx_error_s;

    // Frame sequence, Gray coded from idle through parity to stop
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_DATA = 3'h3,
        ST_PARITY = 3'h2,
        ST_STOP = 3'h6
    } frame_e;
endpackage

//--- uart_txrx.sv
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module uart_txrx (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite write address and data
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [uart_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    // AXI4-Lite write response
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    // AXI4-Lite read
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [uart_pkg::ADDR_W-1:0] araddr_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    // Port pin settings owned by the port block
    input wire logic out_pin_dir_bit_i,
    input wire logic out_pin_latch_i,
    input wire logic in_pin_dir_bit_i,
    // Serial pins
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_o,
    // Completion requests
    output logic tx_done_irq_o,
    output logic rx_done_irq_o,
    output logic rx_err_irq_o
);
    // Bus slave state
    logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff;
    logic arready_ff, rvalid_ff;
    logic [uart_pkg::ADDR_W-1:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic aw_take, w_take, ar_take, do_wr, wr_lane, wr_hit, rd_hit;
    logic nxt_aw_hold, nxt_w_hold, nxt_rvalid;
    logic [31:0] rd_word;

    // Software visible registers
    uart_pkg::uart_mode_s uart_mode_ff;
    uart_pkg::rx_error_s rx_error_status_ff;
    uart_pkg::rx_error_s err_set;
    logic [4:0] baud_divider_ff;
    logic [7:0] rx_buffer_ff;
    logic rx_full_ff;

    // Transmit side
    uart_pkg::frame_e tx_st_ff;
    logic [7:0] tx_shift_ff;
    logic [2:0] tx_idx_ff;
    logic tx_pbit_ff, serial_out_ff, serial_oe_ff, tx_done_ff;
    logic tx_active, tx_start, tx_tick, tx_pbit, tx_dpar;

    // Receive side
    uart_pkg::frame_e rx_st_ff;
    logic [7:0] rx_shift_ff;
    logic [2:0] rx_idx_ff;
    logic rx_par_ff, rx_prev_ff, rx_done_ff, rx_err_ff;
    logic rx_active, rx_line, rx_fall, rx_begin, rx_tick, rx_fin;
    logic pe_now;
    logic [7:0] rx_char;

    // Shared timing
    logic [4:0] k_eff;
    logic [5:0] full_len, half_len, last_bit;
    logic [2:0] last_idx;

    // Bus decode
    assign aw_take = awvalid_i & awready_ff;
    assign w_take = wvalid_i & wready_ff;
    assign ar_take = arvalid_i & arready_ff;
    assign do_wr = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    assign nxt_aw_hold = aw_take | (aw_hold_ff & ~do_wr);
    assign nxt_w_hold = w_take | (w_hold_ff & ~do_wr);
    assign nxt_rvalid = ar_take | (rvalid_ff & ~rready_i);
    assign wr_hit = (awaddr_ff == uart_pkg::UART_MODE_OFF) |
                    (awaddr_ff == uart_pkg::RX_ERROR_STATUS_OFF) |
                    (awaddr_ff == uart_pkg::BAUD_DIVIDER_OFF) |
                    (awaddr_ff == uart_pkg::TX_SHIFT_OFF) |
                    (awaddr_ff == uart_pkg::RX_BUFFER_OFF);
    assign rd_hit = (araddr_i == uart_pkg::UART_MODE_OFF) |
                    (araddr_i == uart_pkg::RX_ERROR_STATUS_OFF) |
                    (araddr_i == uart_pkg::BAUD_DIVIDER_OFF) |
                    (araddr_i == uart_pkg::TX_SHIFT_OFF) |
                    (araddr_i == uart_pkg::RX_BUFFER_OFF);
    // Only byte lane 0 carries register data
    assign wr_lane = do_wr & wstrb_ff;
    assign rd_word =
        (araddr_i == uart_pkg::UART_MODE_OFF) ? {24'h000000, uart_mode_ff} :
        (araddr_i == uart_pkg::RX_ERROR_STATUS_OFF) ?
            {29'h00000000, rx_error_status_ff} :
        (araddr_i == uart_pkg::BAUD_DIVIDER_OFF) ?
            {27'h0000000, baud_divider_ff} :
        (araddr_i == uart_pkg::RX_BUFFER_OFF) ? {24'h000000, rx_buffer_ff} :
        32'h00000000;

    // Write channels: address and data may arrive in either order
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 8'h00;
            wstrb_ff <= 1'b0;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            awready_ff <= ~nxt_aw_hold;
            wready_ff <= ~nxt_w_hold;
            if (aw_take) begin
                awaddr_ff <= awaddr_i;
            end
            if (w_take) begin
                wdata_ff <= wdata_i[7:0];
                wstrb_ff <= wstrb_i[0];
            end
        end
    end

    // Write response is raised on the same edge as the register update
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= uart_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? uart_pkg::RESP_OKAY : uart_pkg::RESP_SLVERR;
        end else if (bready_i) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read channel answers one cycle after the address is taken
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= uart_pkg::RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_hit ? uart_pkg::RESP_OKAY :
                            uart_pkg::RESP_SLVERR;
            end
        end
    end

    // Mode and divider; bit 0 of the mode register always reads 1
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            uart_mode_ff <= uart_pkg::UART_MODE_RST;
            baud_divider_ff <= uart_pkg::BAUD_DIVIDER_RST;
        end else begin
            if (wr_lane && awaddr_ff == uart_pkg::UART_MODE_OFF) begin
                uart_mode_ff <= {wdata_ff[7:1], 1'b1};
            end
            if (wr_lane && awaddr_ff == uart_pkg::BAUD_DIVIDER_OFF) begin
                baud_divider_ff <= wdata_ff[4:0];
            end
        end
    end

    // Bit time of 2k cycles; settings under 8 run as 8
    assign k_eff = (baud_divider_ff < uart_pkg::DIVIDER_MIN) ?
                   uart_pkg::DIVIDER_MIN : baud_divider_ff;
    assign full_len = {k_eff, 1'b0};
    assign half_len = {1'b0, k_eff};
    assign last_idx = uart_mode_ff.char_length_sel ?
                      uart_pkg::LAST_BIT_8 : uart_pkg::LAST_BIT_7;
    assign last_bit = {3'h0, last_idx};

    // Transmit control; a write while busy is dropped
    assign tx_active = uart_mode_ff.uart_power_on &
                       uart_mode_ff.tx_enable_bit;
    assign tx_start = wr_lane & tx_active & (tx_st_ff == uart_pkg::ST_IDLE) &
                      (awaddr_ff == uart_pkg::TX_SHIFT_OFF);
    assign tx_dpar = ^(uart_mode_ff.char_length_sel ? wdata_ff :
                       {1'b0, wdata_ff[6:0]});
    assign tx_pbit =
        (uart_mode_ff.parity_sel == uart_pkg::PAR_EVEN) ? tx_dpar :
        (uart_mode_ff.parity_sel == uart_pkg::PAR_ODD) ? ~tx_dpar :
        1'b0;

    bit_timer #(
        .W(6)
    ) u_tx_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(~tx_active | (tx_st_ff == uart_pkg::ST_IDLE & ~tx_start)),
        .load_i(tx_start | tx_tick),
        .len_i(full_len),
        .tick_o(tx_tick)
    );

    // Transmit sequencer, driving the line one bit time per state step
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st_ff <= uart_pkg::ST_IDLE;
            tx_shift_ff <= 8'h00;
            tx_idx_ff <= 3'h0;
            tx_pbit_ff <= 1'b0;
            serial_out_ff <= 1'b1;
            tx_done_ff <= 1'b0;
        end else begin
            tx_done_ff <= 1'b0;
            if (!tx_active) begin
                tx_st_ff <= uart_pkg::ST_IDLE;
                tx_shift_ff <= 8'h00;
                serial_out_ff <= 1'b1;
            end else if (tx_start) begin
                tx_st_ff <= uart_pkg::ST_START;
                tx_shift_ff <= wdata_ff;
                tx_idx_ff <= 3'h0;
                tx_pbit_ff <= tx_pbit;
                serial_out_ff <= 1'b0;
            end else if (tx_tick) begin
                unique case (tx_st_ff)
                    uart_pkg::ST_IDLE: begin
                    end
                    uart_pkg::ST_START: begin
                        tx_st_ff <= uart_pkg::ST_DATA;
                        serial_out_ff <= tx_shift_ff[0];
                        tx_shift_ff <= tx_shift_ff >> 1;
                    end
                    uart_pkg::ST_DATA: begin
                        if (tx_idx_ff == last_idx) begin
                            tx_idx_ff <= 3'h0;
                            if (uart_mode_ff.parity_sel == uart_pkg::PAR_NONE) begin
                                tx_st_ff <= uart_pkg::ST_STOP;
                                serial_out_ff <= 1'b1;
                            end else begin
                                tx_st_ff <= uart_pkg::ST_PARITY;
                                serial_out_ff <= tx_pbit_ff;
                            end
                        end else begin
                            tx_idx_ff <= tx_idx_ff + 3'h1;
                            serial_out_ff <= tx_shift_ff[0];
                            tx_shift_ff <= tx_shift_ff >> 1;
                        end
                    end
                    uart_pkg::ST_PARITY: begin
                        tx_st_ff <= uart_pkg::ST_STOP;
                        serial_out_ff <= 1'b1;
                    end
                    uart_pkg::ST_STOP: begin
                        if (uart_mode_ff.stop_length_sel && tx_idx_ff == 3'h0) begin
                            tx_idx_ff <= 3'h1;
                        end else begin
                            tx_st_ff <= uart_pkg::ST_IDLE;
                            tx_done_ff <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // The pin is only handed over when the port block agrees
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_oe_ff <= 1'b0;
        end else begin
            serial_oe_ff <= tx_active & ~out_pin_dir_bit_i &
                            out_pin_latch_i;
        end
    end

    // Receive input is forced high unless powered and set as input
    assign rx_line = ~uart_mode_ff.uart_power_on | ~in_pin_dir_bit_i |
                     serial_in_pin_i;
    assign rx_active = uart_mode_ff.uart_power_on &
                       uart_mode_ff.rx_enable_bit;
    assign rx_fall = rx_prev_ff & ~rx_line;
    assign rx_begin = rx_active & rx_fall &
                      (rx_st_ff == uart_pkg::ST_IDLE);
    assign rx_fin = rx_tick & (rx_st_ff == uart_pkg::ST_STOP);
    assign rx_char = uart_mode_ff.char_length_sel ? rx_shift_ff :
                     {1'b0, rx_shift_ff[7:1]};
    assign pe_now =
        ((uart_mode_ff.parity_sel == uart_pkg::PAR_EVEN) & rx_par_ff) |
        ((uart_mode_ff.parity_sel == uart_pkg::PAR_ODD) & ~rx_par_ff);
    assign err_set = '{parity_error_flag: pe_now,
                       framing_error_flag: ~rx_line,
                       overrun_flag: rx_full_ff};

    // Half a bit to the start check, then whole bits land mid-bit
    bit_timer #(
        .W(6)
    ) u_rx_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(~rx_active | (rx_st_ff == uart_pkg::ST_IDLE & ~rx_begin)),
        .load_i(rx_begin | rx_tick),
        .len_i(rx_begin ? half_len : full_len),
        .tick_o(rx_tick)
    );

    // Receive sequencer, independent of the transmitter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st_ff <= uart_pkg::ST_IDLE;
            rx_shift_ff <= 8'h00;
            rx_idx_ff <= 3'h0;
            rx_par_ff <= 1'b0;
            rx_prev_ff <= 1'b1;
        end else begin
            rx_prev_ff <= rx_line;
            if (!rx_active) begin
                rx_st_ff <= uart_pkg::ST_IDLE;
            end else if (rx_begin) begin
                rx_st_ff <= uart_pkg::ST_START;
            end else if (rx_tick) begin
                unique case (rx_st_ff)
                    uart_pkg::ST_IDLE: begin
                    end
                    uart_pkg::ST_START: begin
                        rx_idx_ff <= 3'h0;
                        rx_par_ff <= 1'b0;
                        rx_st_ff <= rx_line ? uart_pkg::ST_IDLE :
                                    uart_pkg::ST_DATA;
                    end
                    uart_pkg::ST_DATA: begin
                        rx_shift_ff <= {rx_line, rx_shift_ff[7:1]};
                        rx_par_ff <= rx_par_ff ^ rx_line;
                        rx_idx_ff <= rx_idx_ff + 3'h1;
                        if ({3'h0, rx_idx_ff} == last_bit) begin
                            rx_st_ff <=
                                (uart_mode_ff.parity_sel == uart_pkg::PAR_NONE) ?
                                uart_pkg::ST_STOP : uart_pkg::ST_PARITY;
                        end
                    end
                    uart_pkg::ST_PARITY: begin
                        rx_par_ff <= rx_par_ff ^ rx_line;
                        rx_st_ff <= uart_pkg::ST_STOP;
                    end
                    uart_pkg::ST_STOP: begin
                        rx_st_ff <= uart_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Frame completion; a set in the cycle of a clearing read wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_error_status_ff <= '0;
            rx_buffer_ff <= uart_pkg::RX_BUFFER_RST;
            rx_full_ff <= 1'b0;
            rx_done_ff <= 1'b0;
            rx_err_ff <= 1'b0;
        end else if (!uart_mode_ff.uart_power_on) begin
            rx_error_status_ff <= '0;
            rx_buffer_ff <= uart_pkg::RX_BUFFER_RST;
            rx_full_ff <= 1'b0;
            rx_done_ff <= 1'b0;
            rx_err_ff <= 1'b0;
        end else begin
            rx_error_status_ff <=
                ((ar_take && araddr_i == uart_pkg::RX_ERROR_STATUS_OFF) ?
                 3'h0 : rx_error_status_ff) |
                (rx_fin ? err_set : 3'h0);
            if (rx_fin && !rx_full_ff) begin
                rx_buffer_ff <= rx_char;
            end
            rx_full_ff <= rx_fin | (rx_full_ff &
                ~(ar_take && araddr_i == uart_pkg::RX_BUFFER_OFF));
            rx_done_ff <= rx_fin & ~(|err_set);
            rx_err_ff <= rx_fin & (|err_set);
        end
    end

    // Outputs straight from flip-flops
    assign awready_o = awready_ff;
    assign wready_o = wready_ff;
    assign bvalid_o = bvalid_ff;
    assign bresp_o = bresp_ff;
    assign arready_o = arready_ff;
    assign rvalid_o = rvalid_ff;
    assign rdata_o = rdata_ff;
    assign rresp_o = rresp_ff;
    assign serial_out_pin_o = serial_out_ff;
    assign serial_out_pin_oe_o = serial_oe_ff;
    assign tx_done_irq_o = tx_done_ff;
    assign rx_done_irq_o = rx_done_ff;
    assign rx_err_irq_o = rx_err_ff;

    // Checks on the frame engines
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_idle_high: assert property (
        tx_st_ff == uart_pkg::ST_IDLE |-> serial_out_ff)
        else $error("tx line low while idle");
    chk_stop_high: assert property (
        tx_st_ff == uart_pkg::ST_STOP |-> serial_out_ff)
        else $error("tx stop bit not high");
    chk_tx_start: assert property (
        tx_start |=> !serial_out_ff && tx_st_ff == uart_pkg::ST_START)
        else $error("tx start bit missing");
    chk_tx_done: assert property (
        tx_done_ff |-> $past(tx_st_ff) == uart_pkg::ST_STOP &&
        tx_st_ff == uart_pkg::ST_IDLE)
        else $error("tx done outside stop end");
    chk_rx_gate: assert property (
        !rx_active |=> rx_st_ff == uart_pkg::ST_IDLE)
        else $error("rx running while disabled");
    chk_false_start: assert property (
        rx_active && rx_tick && rx_line &&
        rx_st_ff == uart_pkg::ST_START |=> rx_st_ff == uart_pkg::ST_IDLE)
        else $error("high start sample accepted");
    chk_overrun_keep: assert property (
        rx_fin && rx_full_ff && uart_mode_ff.uart_power_on |=>
        rx_buffer_ff == $past(rx_buffer_ff) && rx_error_status_ff.overrun_flag)
        else $error("overrun replaced buffer");
    chk_err_request: assert property (
        rx_fin && uart_mode_ff.uart_power_on && |err_set |=>
        rx_err_ff && !rx_done_ff)
        else $error("error frame without error request");
    chk_power_clear: assert property (
        !uart_mode_ff.uart_power_on |=> rx_error_status_ff == 3'h0 &&
        !rx_full_ff && serial_out_ff)
        else $error("state kept while powered down");

    cov_tx_frame: cover property (tx_done_ff);
    cov_rx_frame: cover property (rx_done_ff);
    cov_rx_error: cover property (rx_err_ff && rx_error_status_ff.overrun_flag);
endmodule
`default_nettype wire
